//--- mcu_exec_pkg.sv
// Constants, layouts and types shared by the instruction execution block
package mcu_exec_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 8;
  localparam int PC_W     = 11;
  localparam int OP_W     = 4;
  localparam int APB_AW   = 8;
  localparam int APB_DW   = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [APB_AW-1:0] OFF_INSTR    = 8'h00;
  localparam logic [APB_AW-1:0] OFF_MEM_PTR  = 8'h04;
  localparam logic [APB_AW-1:0] OFF_MEM_DATA = 8'h08;
  localparam logic [APB_AW-1:0] OFF_STATUS   = 8'h0C;
  localparam logic [APB_AW-1:0] OFF_CTRL     = 8'h10;
  localparam logic [APB_AW-1:0] OFF_PC       = 8'h14;
  localparam logic [APB_AW-1:0] OFF_WATCHDOG = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_ZERO     = 0;
  localparam int ST_PWRDN    = 1;
  localparam int ST_EXPIRED  = 2;
  localparam int ST_BUSY     = 3;
  localparam int ST_DOWN     = 4;
  localparam int ST_REFUSED  = 5;
  localparam int ST_WREG_LSB = 8;
  localparam int CTRL_WAKE   = 0;
  localparam int CTRL_WD_EN  = 1;
  localparam int CTRL_CLR    = 2;
  localparam int WD_CNT_LSB  = 8;

  // ----------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] WREG_RST  = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST    = 11'h000;
  localparam logic              WD_EN_RST = 1'b1;
  localparam int                PRESC_W   = 8;
  localparam int                WD_CNT_W  = 8;
  localparam logic [PRESC_W-1:0]  PRESC_LAST = 8'hFF;
  localparam logic [WD_CNT_W-1:0] WD_LAST    = 8'hFF;

  // ----------------------------------------------------------------
  // Opcodes and states
  // ----------------------------------------------------------------
  typedef enum logic [OP_W-1:0] {
    OP_REDUCE_MEMORY_BY_ONE    = 4'h0,
    OP_REDUCE_INTO_WORKING_REG = 4'h1,
    OP_ENTER_POWER_DOWN        = 4'h2,
    OP_ADD_ONE_TO_MEMORY       = 4'h3,
    OP_ADD_ONE_INTO_WORKING_REG = 4'h4,
    OP_UNCONDITIONAL_BRANCH    = 4'h5,
    OP_COPY_OPERAND_MEM_TO_WR  = 4'h6,
    OP_COPY_OPERAND_IMM_TO_WR  = 4'h7,
    OP_COPY_OPERAND_WR_TO_MEM  = 4'h8,
    OP_NO_OPERATION            = 4'hF
  } op_e;

  typedef struct packed {
    logic [PC_W-1:0] operand;
    op_e             op;
  } instr_s;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_EXEC  = 4'b0010,
    ST_DUMMY = 4'b0100,
    ST_SLEEP = 4'b1000
  } state_e;

endpackage : mcu_exec_pkg

//--- mcu_data_mem.sv
// Flip-flop data memory with one write port and two read ports
`timescale 1ns/10ps
module mcu_data_mem #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic [ADDR_W-1:0] dbg_addr,
  output logic      [DATA_W-1:0] dbg_data
);

  localparam int DEPTH = 1 << ADDR_W;

  logic [DATA_W-1:0] cell_q [DEPTH];

  // ----------------------------------------------------------------
  // Storage cells
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    always_ff @(posedge core_clk) begin
      if (wr_en && (wr_addr == ADDR_W'(i))) begin
        cell_q[i] <= wr_data;
      end
    end
  end

  assign rd_data  = cell_q[rd_addr];
  assign dbg_data = cell_q[dbg_addr];

endmodule : mcu_data_mem

//--- mcu_instruction_subset_exec.sv
// Execution unit for a subset of an 8-bit microcontroller instruction set
// Functional notes
// RQ1: In-place decrement writes memory minus one back and updates zero flag.
// RQ2: Decrement into working register leaves memory unaltered, updates zero flag.
// RQ3: In-place increment writes memory plus one back and updates zero flag.
// RQ4: Increment into working register leaves memory unchanged, updates zero flag.
// RQ5: Power-down stops execution and system clock, keeping all stored contents.
// RQ6: Power-down clears watchdog count and its prescaler.
// RQ7: Power-down sets power-down flag, clears watchdog-expired flag, nothing else; a watchdog expiry in that same cycle leaves the expired flag set.
// RQ8: Branch loads program counter from operand and takes two cycles.
// RQ9: Memory to working register copy leaves all flags untouched.
// RQ10: Immediate load into working register leaves all flags untouched.
// RQ11: Working register to memory copy leaves all flags untouched.
// RQ12: Zero flag set when the 8-bit result is zero, else cleared.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps
module mcu_instruction_subset_exec
  import mcu_exec_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [mcu_exec_pkg::APB_AW-1:0] paddr,
  input  wire logic [mcu_exec_pkg::APB_DW-1:0] pwdata,
  output logic      [mcu_exec_pkg::APB_DW-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           sys_clk_en,
  output logic                           power_down_flag,
  output logic                           watchdog_expired_flag
);

  import mcu_exec_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  state_e              state_q,    state_d;
  instr_s              ir_q,       ir_d;
  logic [DATA_W-1:0]   wreg_q,     wreg_d;
  logic                zero_q,     zero_d;
  logic [PC_W-1:0]     pc_q,       pc_d;
  logic                pwrdn_q,    pwrdn_d;
  logic                expired_q,  expired_d;
  logic                clk_en_q,   clk_en_d;
  logic                refused_q,  refused_d;
  logic [ADDR_W-1:0]   ptr_q,      ptr_d;
  logic                wd_en_q,    wd_en_d;
  logic [PRESC_W-1:0]  presc_q,    presc_d;
  logic [WD_CNT_W-1:0] wd_cnt_q,   wd_cnt_d;
  logic [APB_DW-1:0]   prdata_q,   prdata_d;
  logic                pready_q,   pready_d;
  logic                pslverr_q,  pslverr_d;

  logic                apb_setup;
  logic                apb_write;
  logic                instr_wr;
  logic                ctrl_wr;
  logic                mem_data_wr;
  logic                mapped;
  logic                halt_now;
  logic                wd_expire;
  logic                mem_we;
  logic [DATA_W-1:0]   mem_wd;
  logic [DATA_W-1:0]   mem_rd;
  logic [DATA_W-1:0]   dbg_rd;
  logic [ADDR_W-1:0]   opnd_addr;
  logic [DATA_W-1:0]   minus_one;
  logic [DATA_W-1:0]   plus_one;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign apb_setup   = psel & ~penable;
  assign apb_write   = psel & penable & pready_q & pwrite;
  assign instr_wr    = apb_write && (paddr == OFF_INSTR);
  assign ctrl_wr     = apb_write && (paddr == OFF_CTRL);
  assign mem_data_wr = apb_write && (paddr == OFF_MEM_DATA);
  assign mapped      = (paddr == OFF_INSTR)    || (paddr == OFF_MEM_PTR)
                    || (paddr == OFF_MEM_DATA) || (paddr == OFF_STATUS)
                    || (paddr == OFF_CTRL)     || (paddr == OFF_PC)
                    || (paddr == OFF_WATCHDOG);

  // ----------------------------------------------------------------
  // Operand and arithmetic
  // ----------------------------------------------------------------
  assign opnd_addr = ir_q.operand[ADDR_W-1:0];
  assign minus_one = mem_rd - 8'h01;
  assign plus_one  = mem_rd + 8'h01;
  assign halt_now  = (state_q == ST_EXEC) && (ir_q.op == OP_ENTER_POWER_DOWN);

  // ----------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------
  mcu_data_mem #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W)
  ) u_data_mem (
    .core_clk (core_clk),
    .wr_en    (mem_we),
    .wr_addr  (mem_we && (state_q == ST_EXEC) ? opnd_addr : ptr_q),
    .wr_data  (mem_wd),
    .rd_addr  (opnd_addr),
    .rd_data  (mem_rd),
    .dbg_addr (ptr_q),
    .dbg_data (dbg_rd)
  );

  // ----------------------------------------------------------------
  // Watchdog prescaler and counter
  // ----------------------------------------------------------------
  assign wd_expire = wd_en_q && (presc_q == PRESC_LAST) && (wd_cnt_q == WD_LAST);

  always_comb begin
    presc_d  = presc_q;
    wd_cnt_d = wd_cnt_q;
    if (halt_now) begin
      presc_d  = '0;                                         // RQ6
      wd_cnt_d = '0;                                         // RQ6
    end else if (wd_en_q) begin
      presc_d = presc_q + 8'h01;
      if (presc_q == PRESC_LAST) begin
        wd_cnt_d = wd_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      presc_q  <= '0;
      wd_cnt_q <= '0;
    end else begin
      presc_q  <= presc_d;
      wd_cnt_q <= wd_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Execution sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    ir_d      = ir_q;
    wreg_d    = wreg_q;
    zero_d    = zero_q;
    pc_d      = pc_q;
    pwrdn_d   = pwrdn_q;
    expired_d = expired_q;
    clk_en_d  = clk_en_q;
    refused_d = refused_q;
    mem_we    = mem_data_wr;
    mem_wd    = pwdata[DATA_W-1:0];
    if (ctrl_wr && pwdata[CTRL_CLR]) begin
      pwrdn_d   = 1'b0;
      expired_d = 1'b0;
      refused_d = 1'b0;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (instr_wr) begin
          ir_d    = instr_s'(pwdata[PC_W+OP_W-1:0]);
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        pc_d    = pc_q + 11'h001;
        state_d = ST_IDLE;
        case (ir_q.op)
          OP_REDUCE_MEMORY_BY_ONE: begin
            mem_we = 1'b1;                                   // RQ1
            mem_wd = minus_one;                              // RQ1
            zero_d = (minus_one == '0);                      // RQ12
          end
          OP_REDUCE_INTO_WORKING_REG: begin
            wreg_d = minus_one;                              // RQ2
            zero_d = (minus_one == '0);                      // RQ12
          end
          OP_ADD_ONE_TO_MEMORY: begin
            mem_we = 1'b1;                                   // RQ3
            mem_wd = plus_one;                               // RQ3
            zero_d = (plus_one == '0);                       // RQ12
          end
          OP_ADD_ONE_INTO_WORKING_REG: begin
            wreg_d = plus_one;                               // RQ4
            zero_d = (plus_one == '0);                       // RQ12
          end
          OP_ENTER_POWER_DOWN: begin
            pwrdn_d  = 1'b1;                                 // RQ7
            expired_d = 1'b0;                                // RQ7
            clk_en_d = 1'b0;                                 // RQ5
            state_d  = ST_SLEEP;                             // RQ5
          end
          OP_UNCONDITIONAL_BRANCH: begin
            pc_d    = ir_q.operand;                          // RQ8
            state_d = ST_DUMMY;                              // RQ8
          end
          OP_COPY_OPERAND_MEM_TO_WR: begin
            wreg_d = mem_rd;                                 // RQ9
          end
          OP_COPY_OPERAND_IMM_TO_WR: begin
            wreg_d = ir_q.operand[DATA_W-1:0];               // RQ10
          end
          OP_COPY_OPERAND_WR_TO_MEM: begin
            mem_we = 1'b1;                                   // RQ11
            mem_wd = wreg_q;                                 // RQ11
          end
          default: begin
          end
        endcase
      end
      ST_DUMMY: begin
        state_d = ST_IDLE;                                   // RQ8
      end
      ST_SLEEP: begin
        if ((ctrl_wr && pwdata[CTRL_WAKE]) || wd_expire) begin
          clk_en_d = 1'b1;
          state_d  = ST_IDLE;
        end
      end
    endcase
    if (instr_wr && (state_q != ST_IDLE)) begin
      refused_d = 1'b1;
    end
    if (wd_expire) begin
      expired_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q   <= ST_IDLE;
      ir_q      <= '{operand: '0, op: OP_NO_OPERATION};
      wreg_q    <= WREG_RST;
      zero_q    <= 1'b0;
      pc_q      <= PC_RST;
      pwrdn_q   <= 1'b0;
      expired_q <= 1'b0;
      clk_en_q  <= 1'b1;
      refused_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      ir_q      <= ir_d;
      wreg_q    <= wreg_d;
      zero_q    <= zero_d;
      pc_q      <= pc_d;
      pwrdn_q   <= pwrdn_d;
      expired_q <= expired_d;
      clk_en_q  <= clk_en_d;
      refused_q <= refused_d;
    end
  end

  // ----------------------------------------------------------------
  // Software control registers
  // ----------------------------------------------------------------
  always_comb begin
    ptr_d   = ptr_q;
    wd_en_d = wd_en_q;
    if (apb_write && (paddr == OFF_MEM_PTR)) begin
      ptr_d = pwdata[ADDR_W-1:0];
    end
    if (ctrl_wr) begin
      wd_en_d = pwdata[CTRL_WD_EN];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ptr_q   <= '0;
      wd_en_q <= WD_EN_RST;
    end else begin
      ptr_q   <= ptr_d;
      wd_en_q <= wd_en_d;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  always_comb begin
    prdata_d  = '0;
    pready_d  = apb_setup;
    pslverr_d = apb_setup && !mapped;
    if (apb_setup && !pwrite) begin
      unique case (paddr)
        OFF_INSTR: begin
          prdata_d[PC_W+OP_W-1:0] = ir_q;
        end
        OFF_MEM_PTR: begin
          prdata_d[ADDR_W-1:0] = ptr_q;
        end
        OFF_MEM_DATA: begin
          prdata_d[DATA_W-1:0] = dbg_rd;
        end
        OFF_STATUS: begin
          prdata_d[ST_ZERO]    = zero_q;
          prdata_d[ST_PWRDN]   = pwrdn_q;
          prdata_d[ST_EXPIRED] = expired_q;
          prdata_d[ST_BUSY]    = (state_q != ST_IDLE);
          prdata_d[ST_DOWN]    = (state_q == ST_SLEEP);
          prdata_d[ST_REFUSED] = refused_q;
          prdata_d[ST_WREG_LSB +: DATA_W] = wreg_q;
        end
        OFF_CTRL: begin
          prdata_d[CTRL_WD_EN] = wd_en_q;
        end
        OFF_PC: begin
          prdata_d[PC_W-1:0] = pc_q;
        end
        OFF_WATCHDOG: begin
          prdata_d[PRESC_W-1:0]             = presc_q;
          prdata_d[WD_CNT_LSB +: WD_CNT_W]  = wd_cnt_q;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign sys_clk_en            = clk_en_q;
  assign power_down_flag       = pwrdn_q;
  assign watchdog_expired_flag = expired_q;

endmodule : mcu_instruction_subset_exec

//--- mcu_exec_chk.sv
// Port-level concurrent checks for the instruction execution block
`timescale 1ns/10ps
module mcu_exec_chk (
  input wire logic                          core_clk,
  input wire logic                          sys_rst,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [mcu_exec_pkg::APB_AW-1:0] paddr,
  input wire logic [mcu_exec_pkg::APB_DW-1:0] pwdata,
  input wire logic [mcu_exec_pkg::APB_DW-1:0] prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire logic                          sys_clk_en,
  input wire logic                          power_down_flag,
  input wire logic                          watchdog_expired_flag
);
  import mcu_exec_pkg::*;
  // ----------------------------------------------------------------
  // Helper terms
  // ----------------------------------------------------------------
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pready && pwrite && (paddr == OFF_CTRL);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_ready_next; psel && !penable |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_err_map;
    pready && (paddr[1:0] == 2'b00) |-> pslverr == (paddr > OFF_WATCHDOG);
  endproperty
  property p_rdata_idle; !pready || pwrite |-> prdata == '0; endproperty
  property p_down_flags;
    $fell(sys_clk_en) |-> power_down_flag && !watchdog_expired_flag;
  endproperty
  property p_pwrdn_sleep; $rose(power_down_flag) |-> !sys_clk_en; endproperty
  property p_pwrdn_keep;
    $fell(power_down_flag) |-> $past(ctrl_wr && pwdata[CTRL_CLR]);
  endproperty
  property p_expired_keep;
    $fell(watchdog_expired_flag) |-> $past(ctrl_wr && pwdata[CTRL_CLR]) || !sys_clk_en;
  endproperty
  property p_wake_cause;
    $rose(sys_clk_en) |-> $past(ctrl_wr && pwdata[CTRL_WAKE]) || watchdog_expired_flag;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready missing after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_err_map: assert property (p_err_map) else $error("pslverr does not match address map");
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero outside read");
  a_down_flags: assert property (p_down_flags) else $error("flags wrong at power-down");
  a_pwrdn_sleep: assert property (p_pwrdn_sleep) else $error("flag set without clock stop");
  a_pwrdn_keep: assert property (p_pwrdn_keep) else $error("power-down flag lost");
  a_expired_keep: assert property (p_expired_keep) else $error("expired flag lost");
  a_wake_cause: assert property (p_wake_cause) else $error("clock restarted on its own");
  c_unmapped: cover property (pslverr);
  c_sleep: cover property ($fell(sys_clk_en));
  c_expire: cover property ($rose(watchdog_expired_flag));
endmodule : mcu_exec_chk

bind mcu_instruction_subset_exec mcu_exec_chk u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sys_clk_en(sys_clk_en), .power_down_flag(power_down_flag),
  .watchdog_expired_flag(watchdog_expired_flag)
);

//--- testbench.sv
// Self-checking testbench for the instruction execution block
`timescale 1ns/10ps
module testbench;
  import mcu_exec_pkg::*;
  // ----------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------
  logic              core_clk;
  logic              sys_rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata;
  logic [APB_DW-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              sys_clk_en;
  logic              power_down_flag;
  logic              watchdog_expired_flag;
  int                error_cnt;
  int                num_checks;
  int                n;
  logic [31:0]       rd;
  logic              err;
  logic [7:0]        m_wr;
  logic [7:0]        m_mem;
  logic              m_z;
  logic [10:0]       m_pc;
  logic [7:0]        a;
  logic [7:0]        v;
  logic [7:0]        imm;
  logic [7:0]        imm2;
  logic [7:0]        corner[3] = '{8'h01, 8'hFF, 8'h00};
  logic [10:0]       tgt[3] = '{11'h7FF, 11'h001, 11'h2A5};
  op_e               ops[7] = '{OP_REDUCE_MEMORY_BY_ONE, OP_COPY_OPERAND_MEM_TO_WR,
                                OP_REDUCE_INTO_WORKING_REG, OP_COPY_OPERAND_IMM_TO_WR,
                                OP_ADD_ONE_TO_MEMORY, OP_COPY_OPERAND_WR_TO_MEM,
                                OP_ADD_ONE_INTO_WORKING_REG};

  mcu_instruction_subset_exec u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_clk_en(sys_clk_en), .power_down_flag(power_down_flag),
    .watchdog_expired_flag(watchdog_expired_flag)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // Tasks and expectation function
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_val({31'h0, got}, {31'h0, exp}, what);
  endtask : chk_bit

  task automatic apb(input logic wr, input logic [APB_AW-1:0] ad, input logic [APB_DW-1:0] d);
    int k;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t no pready", $time);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic exec(input op_e op, input logic [10:0] opd);
    instr_s ins;
    ins.operand = opd;
    ins.op      = op;
    apb(1'b1, OFF_INSTR, {17'h0, ins});
    m_pc = (op == OP_UNCONDITIONAL_BRANCH) ? opd : m_pc + 11'h001;
  endtask : exec

  // Returns expected memory, working register and zero flag
  function automatic logic [16:0] f_exp(op_e op, logic [7:0] mv, logic [7:0] w,
                                        logic [7:0] x, logic z);
    logic [7:0] r;
    r = (op == OP_REDUCE_MEMORY_BY_ONE || op == OP_REDUCE_INTO_WORKING_REG) ? mv - 8'h01
                                                                          : mv + 8'h01;
    case (op)
      OP_REDUCE_MEMORY_BY_ONE, OP_ADD_ONE_TO_MEMORY: f_exp = {r, w, r == 8'h00};
      OP_REDUCE_INTO_WORKING_REG, OP_ADD_ONE_INTO_WORKING_REG: f_exp = {mv, r, r == 8'h00};
      OP_COPY_OPERAND_MEM_TO_WR: f_exp = {mv, mv, z};
      OP_COPY_OPERAND_IMM_TO_WR: f_exp = {mv, x, z};
      OP_COPY_OPERAND_WR_TO_MEM: f_exp = {w, w, z};
      default: f_exp = {mv, w, z};
    endcase
  endfunction : f_exp
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    $display("[ERR] %0t run did not finish", $time);
    stop_test();
  end

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    error_cnt = 0;
    num_checks = 0;
    m_wr = WREG_RST;
    m_z = 1'b0;
    m_pc = PC_RST;
    void'($urandom(32'h5B61E16E));
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(1'b0, OFF_STATUS, '0);
    chk_val(rd, 32'h00000000, "status after reset");
    apb(1'b0, OFF_CTRL, '0);
    chk_val(rd, 32'h00000002, "ctrl after reset");
    for (int i = 0; i < 8; i++) begin
      foreach (ops[k]) begin
        a    = (i == 0) ? 8'h00 : 8'($urandom);
        v    = (i < 3) ? corner[i] : 8'($urandom);
        imm  = 8'($urandom);
        imm2 = (i == 1) ? 8'h00 : 8'($urandom);
        apb(1'b1, OFF_MEM_PTR, {24'h0, a});
        apb(1'b1, OFF_MEM_DATA, {24'h0, v});
        exec(OP_COPY_OPERAND_IMM_TO_WR, {3'h0, imm});
        m_wr = imm;
        exec(ops[k], {3'h0, (ops[k] == OP_COPY_OPERAND_IMM_TO_WR) ? imm2 : a});
        {m_mem, m_wr, m_z} = f_exp(ops[k], v, m_wr, imm2, m_z);
        apb(1'b0, OFF_STATUS, '0);
        chk_val({24'h0, rd[15:8]}, {24'h0, m_wr}, "working reg");
        chk_bit(rd[ST_ZERO], m_z, "zero flag");
        apb(1'b0, OFF_MEM_DATA, '0);
        chk_val(rd, {24'h0, m_mem}, "memory");
      end
    end
    foreach (tgt[j]) begin
      exec(OP_UNCONDITIONAL_BRANCH, tgt[j]);
      apb(1'b0, OFF_STATUS, '0);
      chk_bit(rd[ST_BUSY], 1'b1, "dummy cycle");
      apb(1'b0, OFF_PC, '0);
      chk_val(rd, {21'h0, m_pc}, "branch target");
      exec(OP_NO_OPERATION, 11'h000);
      apb(1'b0, OFF_PC, '0);
      chk_val(rd, {21'h0, m_pc}, "after branch");
    end
    apb(1'b0, 8'h40, '0);
    chk_val({rd[30:0], err}, 32'h00000001, "unmapped read");
    apb(1'b1, 8'h1C, 32'hFFFFFFFF);
    chk_bit(err, 1'b1, "unmapped write");
    apb(1'b1, OFF_CTRL, 32'h00000006);
    repeat (300) @(posedge core_clk);
    apb(1'b0, OFF_WATCHDOG, '0);
    chk_bit(rd[15:8] != 8'h00, 1'b1, "watchdog running");
    exec(OP_ENTER_POWER_DOWN, 11'h000);
    repeat (2) @(posedge core_clk);
    chk_bit(sys_clk_en, 1'b0, "clock stopped");
    chk_bit(power_down_flag, 1'b1, "power-down flag");
    apb(1'b0, OFF_WATCHDOG, '0);
    chk_bit(rd[15:8] == 8'h00 && rd[7:0] < 8'h10, 1'b1, "watchdog cleared");
    apb(1'b1, OFF_INSTR, 32'h00000007);
    apb(1'b0, OFF_STATUS, '0);
    chk_bit(rd[ST_DOWN] && rd[ST_REFUSED], 1'b1, "execution stopped");
    chk_val({24'h0, rd[15:8]}, {24'h0, m_wr}, "working reg kept");
    chk_bit(rd[ST_ZERO], m_z, "zero kept");
    apb(1'b0, OFF_MEM_DATA, '0);
    chk_val(rd, {24'h0, m_mem}, "memory kept");
    apb(1'b1, OFF_CTRL, 32'h00000003);
    repeat (2) @(posedge core_clk);
    chk_bit(sys_clk_en, 1'b1, "woken");
    n = 0;
    while (watchdog_expired_flag !== 1'b1 && n < 70000) begin
      @(posedge core_clk);
      n++;
    end
    chk_bit(watchdog_expired_flag, 1'b1, "watchdog expiry");
    exec(OP_ENTER_POWER_DOWN, 11'h000);
    repeat (2) @(posedge core_clk);
    chk_bit(watchdog_expired_flag, 1'b0, "expired flag cleared");
    chk_bit(power_down_flag, 1'b1, "power-down flag again");
    apb(1'b1, OFF_CTRL, 32'h00000003);
    apb(1'b1, OFF_CTRL, 32'h00000006);
    repeat (2) @(posedge core_clk);
    chk_bit(power_down_flag, 1'b0, "flags cleared");
    stop_test();
  end
endmodule : testbench
